// >>> logic/nfbr_framer.sv
// Bit rate and type A framing configuration with transmit and receive framer
//
// Contract
// - Transmit rate field bits 5:4 selects fc/128, fc/64, fc/32 or fc/16.
// - Receive rate field bits 1:0 uses the same divide-ratio coding.
// - Unsupported pulse width setting for the transmit rate disables transmit and receive instead of a default.
// - Parity suppression sends the data stream with no parity bits.
// - Raw receive puts parity bits into data, skips checks; 106 kbit/s only.
// - Transport frame adds F0 and length on transmit, drops leading F0 on receive.
// - Four-bit pulse width field bits 4:1 sets pause in carrier periods.
// - At fc/128 pause is 35 plus the signed field, 27 to 42.
// - Faster rates use bases 18, 9, 5 with limited ranges; others unsupported.
// - Passive target and detection modes drive field with the load setting.
// - Target with top mode bit set is detection; sub-bits pick type F, A.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "nfbr_params.svh"

module nfbr_framer import nfbr_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Carrier period strobe
    input wire logic carrier_tick,
    // Transmit byte stream
    input wire logic tx_start,
    input wire logic [7:0] tx_len,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx_busy,
    output logic tx_bit,
    output logic tx_pause,
    // Receive bit stream
    input wire logic rx_frame_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_parity_err,
    // Configuration outputs
    output logic link_enabled,
    output logic rx_raw_mode,
    output logic antcoll_frame,
    output logic [6:0] pulse_width,
    output logic [1:0] rf_load_sel,
    output logic detect_type_f_rate,
    output logic detect_type_a_rate
);
    logic [7:0] rate_q, frame_q, mode_q;
    logic perr_q, ack_q;
    logic [31:0] dat_q;
    nfbr_rate_t tx_rate, rx_rate;
    logic [3:0] pw_field;
    logic signed [6:0] pw_s, pw_min, pw_max;
    logic pw_ok, transport_frame_enable;
    logic [3:0] op_mode;
    logic is_target, rate_detect, passive_target;
    logic [7:0] bit_len, tick_q;
    logic [3:0] nbit_q;
    logic [8:0] sh_q;
    logic [7:0] left_q;
    nfbr_src_t src_q;
    nfbr_tx_state_t tx_state_q;
    logic [7:0] load_byte;
    logic load_now;
    logic [3:0] rcnt_q;
    logic [7:0] rbyte_q;
    logic rfirst_q;
    logic [7:0] rx_byte_q;
    logic rx_valid_q, rx_done, rx_perr_ev;
    logic [7:0] rx_full;
    logic req, wr_now;
    logic [5:0] idx;
    assign idx = wb_adr_i[7:2];
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_now = req && wb_we_i && ack_q && wb_sel_i[0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign tx_rate = nfbr_rate_t'(rate_q[`NFBR_TXR_LSB+:2]);
    assign rx_rate = nfbr_rate_t'(rate_q[`NFBR_RXR_LSB+:2]);
    assign pw_field = frame_q[`NFBR_PW_LSB+:4];
    assign transport_frame_enable = frame_q[`NFBR_TFRM];
    assign antcoll_frame = frame_q[`NFBR_ANTCL];
    assign op_mode = mode_q[`NFBR_OM_LSB+:4];
    assign is_target = mode_q[`NFBR_TARGET];
    // Signed pulse offset on a per-rate base
    always_comb begin
        case (tx_rate)
            NFBR_RATE_106: begin
                pw_s = `NFBR_PW_BASE0 + 7'(signed'(pw_field));
                pw_min = `NFBR_PW_BASE0 - 7'sd8;
                pw_max = `NFBR_PW_BASE0 + 7'sd7;
            end
            NFBR_RATE_212: begin
                pw_s = `NFBR_PW_BASE1 + 7'(signed'(pw_field));
                pw_min = `NFBR_PW_MIN1;
                pw_max = `NFBR_PW_MAX1;
            end
            NFBR_RATE_424: begin
                pw_s = `NFBR_PW_BASE2 + 7'(signed'(pw_field));
                pw_min = `NFBR_PW_MIN2;
                pw_max = `NFBR_PW_MAX2;
            end
            default: begin
                pw_s = `NFBR_PW_BASE3 + 7'(signed'(pw_field));
                pw_min = `NFBR_PW_MIN3;
                pw_max = `NFBR_PW_MAX3;
            end
        endcase
    end
    // Codes outside the usable range are unsupported
    assign pw_ok = (pw_s >= pw_min) && (pw_s <= pw_max);
    assign pulse_width = pw_s;
    assign link_enabled = pw_ok;
    // Raw capture only at 106 kbit/s
    assign rx_raw_mode = frame_q[`NFBR_RAW_RX] && (rx_rate == NFBR_RATE_106);
    assign rate_detect = is_target && op_mode[3];
    assign detect_type_f_rate = rate_detect && op_mode[2];
    assign detect_type_a_rate = rate_detect && op_mode[0];
    assign passive_target = is_target
        && (op_mode == `NFBR_OM_PT_A || op_mode == `NFBR_OM_PT_F);
    // Load setting used only while acting as passive target or in detection mode
    assign rf_load_sel = (passive_target || rate_detect) ? mode_q[`NFBR_LOAD_LSB+:2] : 2'b00;
    // Bus answer one cycle after the request; ack drops the cycle after
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req && !ack_q;
            dat_q <= 32'h0000_0000;
            if (req && !ack_q && !wb_we_i) begin
                case (idx)
                    `NFBR_IDX_RATE: dat_q[7:0] <= rate_q;
                    `NFBR_IDX_FRAME: dat_q[7:0] <= frame_q;
                    `NFBR_IDX_MODE: dat_q[7:0] <= mode_q;
                    `NFBR_IDX_STAT: dat_q[7:0] <= {5'b0_0000, perr_q, tx_busy, link_enabled};
                    default: dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rate_q <= `NFBR_RST_RATE;
            frame_q <= `NFBR_RST_FRAME;
            mode_q <= `NFBR_RST_MODE;
        end else if (wr_now) begin
            if (idx == `NFBR_IDX_RATE) begin
                rate_q <= wb_dat_i[7:0] & `NFBR_RATE_MASK;
            end
            if (idx == `NFBR_IDX_FRAME) begin
                frame_q <= wb_dat_i[7:0];
            end
            if (idx == `NFBR_IDX_MODE) begin
                mode_q <= wb_dat_i[7:0] & `NFBR_MODE_MASK;
            end
        end
    end
    // Sticky parity error; a new error beats a write-one clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            perr_q <= 1'b0;
        end else if (rx_perr_ev) begin
            perr_q <= 1'b1;
        end else if (wr_now && idx == `NFBR_IDX_STAT && wb_dat_i[`NFBR_ST_PERR]) begin
            perr_q <= 1'b0;
        end
    end
    assign rx_parity_err = perr_q;
    // Transmit framer
    assign bit_len = `NFBR_BIT_FC128 >> tx_rate;
    assign tx_busy = (tx_state_q != NFBR_TX_IDLE);
    assign tx_bit = (tx_state_q == NFBR_TX_BIT) && sh_q[0];
    assign tx_pause = tx_bit && ({1'b0, tick_q} < {1'b0, pw_s});
    assign tx_ready = (tx_state_q == NFBR_TX_BYTE) && (src_q == NFBR_SRC_DATA)
        && (left_q != 8'h00) && link_enabled;
    always_comb begin
        case (src_q)
            // Start byte then length, which counts itself
            NFBR_SRC_START: load_byte = `NFBR_START_BYTE;
            NFBR_SRC_LEN: load_byte = tx_len + 8'h01;
            default: load_byte = tx_data;
        endcase
    end
    assign load_now = (tx_state_q == NFBR_TX_BYTE)
        && ((src_q != NFBR_SRC_DATA) || (tx_ready && tx_valid));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_q <= NFBR_TX_IDLE;
            src_q <= NFBR_SRC_START;
            left_q <= 8'h00;
            sh_q <= 9'h000;
            nbit_q <= 4'h0;
            tick_q <= 8'h00;
        end else if (!link_enabled) begin
            tx_state_q <= NFBR_TX_IDLE;
        end else begin
            case (tx_state_q)
                NFBR_TX_IDLE: begin
                    if (tx_start) begin
                        src_q <= transport_frame_enable ? NFBR_SRC_START : NFBR_SRC_DATA;
                        left_q <= tx_len;
                        tx_state_q <= NFBR_TX_BYTE;
                    end
                end
                NFBR_TX_BYTE: begin
                    if (src_q == NFBR_SRC_DATA && left_q == 8'h00) begin
                        tx_state_q <= NFBR_TX_IDLE;
                    end else if (load_now) begin
                        // Odd parity in bit 8
                        sh_q <= {~^load_byte, load_byte};
                        // Eight bits per byte without parity
                        nbit_q <= frame_q[`NFBR_NO_TX_PAR] ? 4'h8 : 4'h9;
                        tick_q <= 8'h00;
                        if (src_q == NFBR_SRC_DATA) begin
                            left_q <= left_q - 8'h01;
                        end
                        src_q <= (src_q == NFBR_SRC_START) ? NFBR_SRC_LEN : NFBR_SRC_DATA;
                        tx_state_q <= NFBR_TX_BIT;
                    end
                end
                NFBR_TX_BIT: begin
                    if (carrier_tick) begin
                        if (tick_q == bit_len - 8'h01) begin
                            tick_q <= 8'h00;
                            sh_q <= {1'b0, sh_q[8:1]};
                            nbit_q <= nbit_q - 4'h1;
                            if (nbit_q == 4'h1) begin
                                tx_state_q <= NFBR_TX_BYTE;
                            end
                        end else begin
                            tick_q <= tick_q + 8'h01;
                        end
                    end
                end
                default: tx_state_q <= NFBR_TX_IDLE;
            endcase
        end
    end
    // Receive deframer; parity bit is the ninth bit, checked against the byte and not stored
    assign rx_full = rx_raw_mode ? {rx_bit, rbyte_q[7:1]} : rbyte_q;
    assign rx_done = rx_bit_valid && link_enabled
        && (rcnt_q == (rx_raw_mode ? 4'h7 : 4'h8));
    // Parity checked only outside raw mode
    assign rx_perr_ev = rx_done && !rx_raw_mode && (rx_bit == ^rbyte_q);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_q <= 4'h0;
            rbyte_q <= 8'h00;
            rfirst_q <= 1'b0;
            rx_byte_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (rx_frame_start || !link_enabled) begin
                rcnt_q <= 4'h0;
                rfirst_q <= 1'b1;
            end else if (rx_bit_valid) begin
                if (rx_done) begin
                    rcnt_q <= 4'h0;
                    rfirst_q <= 1'b0;
                    rx_byte_q <= rx_full;
                    rx_valid_q <= !(transport_frame_enable && rfirst_q
                        && rx_full == `NFBR_START_BYTE);
                end else begin
                    rcnt_q <= rcnt_q + 4'h1;
                    rbyte_q <= {rx_bit, rbyte_q[7:1]};
                end
            end
        end
    end
    assign rx_byte = rx_byte_q;
    assign rx_byte_valid = rx_valid_q;
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_start_loaded;
        tx_state_q == NFBR_TX_BYTE && src_q == NFBR_SRC_START && link_enabled;
    endsequence
    a_bus_answer: assert property (@(posedge mclk) disable iff (!rst_n)
        s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (rate_q & ~`NFBR_RATE_MASK) == 8'h00)
        else $error("reserved rate bits stored");
    a_disable_tx: assert property (@(posedge mclk) disable iff (!rst_n)
        !link_enabled |=> !tx_busy && !rx_byte_valid)
        else $error("link active while disabled");
    a_pw_slow_rate: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_rate == NFBR_RATE_106 |-> pulse_width >= 7'd27 && pulse_width <= 7'd42 && pw_ok)
        else $error("slow rate pulse width out of range");
    a_pw_fast_rate: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_rate == NFBR_RATE_848 && pw_ok |-> pulse_width >= 7'd2 && pulse_width <= 7'd8)
        else $error("fast rate pulse width out of range");
    a_start_byte: assert property (@(posedge mclk) disable iff (!rst_n)
        s_start_loaded |=> sh_q[7:0] == `NFBR_START_BYTE && src_q == NFBR_SRC_LEN)
        else $error("start byte not sent first");
    a_no_parity: assert property (@(posedge mclk) disable iff (!rst_n)
        load_now && link_enabled && frame_q[`NFBR_NO_TX_PAR] |=> nbit_q == 4'h8)
        else $error("parity bit sent while suppressed");
    a_pause_bound: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_pause |-> tx_busy && {1'b0, tick_q} < {1'b0, pulse_width} && sh_q[0])
        else $error("pause outside its width");
    a_raw_rate: assert property (@(posedge mclk) disable iff (!rst_n)
        rx_raw_mode |-> rx_rate == NFBR_RATE_106 && !rx_perr_ev)
        else $error("raw capture at wrong rate");
    a_load_setting: assert property (@(posedge mclk) disable iff (!rst_n)
        rf_load_sel != 2'b00 |-> is_target && (op_mode[3] || passive_target))
        else $error("load setting outside target modes");
    a_detect_bits: assert property (@(posedge mclk) disable iff (!rst_n)
        (detect_type_f_rate || detect_type_a_rate) |-> is_target && op_mode[3])
        else $error("detection outside detection mode");
endmodule : nfbr_framer

// >>> pkg/nfbr_params.svh
// Offsets, field positions, reset values and timing figures of the framer
`ifndef NFBR_PARAMS_SVH
`define NFBR_PARAMS_SVH
// Register indexes; byte address is four times the index
`define NFBR_IDX_RATE 6'h04
`define NFBR_IDX_FRAME 6'h05
`define NFBR_IDX_MODE 6'h06
`define NFBR_IDX_STAT 6'h07
`define NFBR_RST_RATE 8'h00
`define NFBR_RST_FRAME 8'h00
`define NFBR_RST_MODE 8'h00
`define NFBR_RATE_MASK 8'h33
`define NFBR_MODE_MASK 8'hFB
// Bit rate register fields
`define NFBR_TXR_LSB 4
`define NFBR_RXR_LSB 0
// Framing register fields
`define NFBR_NO_TX_PAR 7
`define NFBR_RAW_RX 6
`define NFBR_TFRM 5
`define NFBR_PW_LSB 1
`define NFBR_ANTCL 0
// Mode register fields
`define NFBR_TARGET 7
`define NFBR_OM_LSB 3
`define NFBR_LOAD_LSB 0
// Status register fields
`define NFBR_ST_EN 0
`define NFBR_ST_BUSY 1
`define NFBR_ST_PERR 2
// Frame bytes and target mode codes
`define NFBR_START_BYTE 8'hF0
`define NFBR_OM_PT_A 4'h1
`define NFBR_OM_PT_F 4'h4
// Carrier periods per bit at fc/128
`define NFBR_BIT_FC128 8'h80
// Pulse base widths and usable ranges in carrier periods
`define NFBR_PW_BASE0 7'sd35
`define NFBR_PW_BASE1 7'sd18
`define NFBR_PW_BASE2 7'sd9
`define NFBR_PW_BASE3 7'sd5
`define NFBR_PW_MIN1 7'sd12
`define NFBR_PW_MAX1 7'sd24
`define NFBR_PW_MIN2 7'sd5
`define NFBR_PW_MAX2 7'sd13
`define NFBR_PW_MIN3 7'sd2
`define NFBR_PW_MAX3 7'sd8
`endif

// >>> pkg/nfbr_pkg.sv
// Types shared by the framer
package nfbr_pkg;
    typedef enum logic [1:0] {
        NFBR_RATE_106,
        NFBR_RATE_212,
        NFBR_RATE_424,
        NFBR_RATE_848
    } nfbr_rate_t;
    typedef enum logic [1:0] {
        NFBR_SRC_START,
        NFBR_SRC_LEN,
        NFBR_SRC_DATA
    } nfbr_src_t;
    typedef enum {
        NFBR_TX_IDLE,
        NFBR_TX_BYTE,
        NFBR_TX_BIT
    } nfbr_tx_state_t;
endpackage : nfbr_pkg

// >>> tb/nfbr_peer.sv
// RF peer model: carrier ticks, received bit source and pause monitor
`timescale 1ns/10ps

module nfbr_peer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Transmit side seen over the air
    input wire logic tx_pause,
    input wire logic tx_busy,
    // Carrier and receive side
    output logic carrier_tick,
    output logic rx_frame_start,
    output logic rx_bit_valid,
    output logic rx_bit
);
    int n_pause = 0;
    int last_pw = 0;
    int pw_cnt = 0;
    int busy_ticks = 0;
    logic pause_q = 1'b0;
    initial begin
        carrier_tick = 1'b0;
        rx_frame_start = 1'b0;
        rx_bit_valid = 1'b0;
        rx_bit = 1'b0;
    end
    // Carrier at half the system clock keeps frames short
    always @(posedge mclk) carrier_tick <= ~carrier_tick;
    always @(posedge mclk) begin
        pause_q <= tx_pause;
        if (tx_pause && carrier_tick) pw_cnt <= pw_cnt + 1;
        if (pause_q && !tx_pause) begin
            n_pause <= n_pause + 1;
            last_pw <= pw_cnt;
            pw_cnt <= 0;
        end
        if (tx_busy && carrier_tick) busy_ticks <= busy_ticks + 1;
    end
    task automatic frame_start();
        @(posedge mclk);
        rx_frame_start <= 1'b1;
        @(posedge mclk);
        rx_frame_start <= 1'b0;
    endtask : frame_start
    // Idle line shows the inverse of the last bit, never a stale copy
    task automatic send_bits(input logic [8:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            rx_bit_valid <= 1'b1;
            rx_bit <= bits[i];
            @(posedge mclk);
            rx_bit_valid <= 1'b0;
            rx_bit <= ~bits[i];
        end
    endtask : send_bits
endmodule : nfbr_peer

// >>> tb/tb.sv
// Self-checking bench for the bit rate and type A framing block
`timescale 1ns/10ps
`include "nfbr_params.svh"

module tb;
    logic mclk = 1'b0, rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic wb_ack_o, carrier_tick, rx_frame_start, rx_bit_valid, rx_bit;
    logic tx_start = 1'b0, tx_valid = 1'b0;
    logic [7:0] tx_len = 8'h00, tx_data = 8'h00, rx_byte, rx_last;
    logic tx_ready, tx_busy, tx_bit, tx_pause, rx_byte_valid, rx_parity_err;
    logic link_enabled, rx_raw_mode, antcoll_frame, detect_type_f_rate, detect_type_a_rate;
    logic [6:0] pulse_width;
    logic [1:0] rf_load_sel;
    int n_errors = 0, n_tests = 0, n_rx = 0, bt;
    int t_rate [12] = '{0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3};
    logic [3:0] t_code [12] = '{4'h7, 4'h8, 4'h6, 4'h7, 4'hA, 4'h9, 4'h4, 4'hC, 4'h5, 4'h3,
        4'hD, 4'hC};
    // Zero width marks a code that must disable the link
    int t_pw [12] = '{42, 27, 24, 0, 12, 0, 13, 5, 0, 8, 2, 0};

    always #4 mclk = ~mclk;

    nfbr_framer u_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .carrier_tick(carrier_tick),
        .tx_start(tx_start), .tx_len(tx_len), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .tx_busy(tx_busy), .tx_bit(tx_bit), .tx_pause(tx_pause),
        .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_parity_err(rx_parity_err),
        .link_enabled(link_enabled), .rx_raw_mode(rx_raw_mode), .antcoll_frame(antcoll_frame),
        .pulse_width(pulse_width), .rf_load_sel(rf_load_sel),
        .detect_type_f_rate(detect_type_f_rate), .detect_type_a_rate(detect_type_a_rate));

    nfbr_peer u_peer (.mclk(mclk), .rst_n(rst_n), .tx_pause(tx_pause), .tx_busy(tx_busy),
        .carrier_tick(carrier_tick), .rx_frame_start(rx_frame_start),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

    always @(posedge mclk) begin
        if (rx_byte_valid === 1'b1) begin
            n_rx <= n_rx + 1;
            rx_last <= rx_byte;
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic hang(input string what);
        n_errors++;
        $display("BAD %s expected done seen timeout", what);
        stop_test();
    endtask : hang

    // Request held until ack is sampled; data taken at that edge
    task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] wd);
        int i;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h00_0000, wd};
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 20) hang("wb ack");
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // A write lands at the ack edge; outputs settle before callers look
        @(negedge mclk);
    endtask : wb

    task automatic rdc(input string what, input logic [5:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk(what, {24'h00_0000, exp}, rd);
    endtask : rdc

    // One payload byte; header bytes come first when transport framing is on
    task automatic send_frame(input logic [7:0] d);
        int i;
        u_peer.n_pause = 0;
        u_peer.busy_ticks = 0;
        @(posedge mclk);
        tx_start <= 1'b1;
        tx_len <= 8'h01;
        @(posedge mclk);
        tx_start <= 1'b0;
        tx_valid <= 1'b1;
        tx_data <= d;
        for (i = 0; i < 20000 && tx_ready !== 1'b1; i++) @(posedge mclk);
        if (i == 20000) hang("tx ready");
        tx_valid <= 1'b0;
        @(negedge mclk);
        chk("first bit", 32'(d[0]), tx_bit);
        for (i = 0; i < 20000 && tx_busy !== 1'b0; i++) @(posedge mclk);
        if (i == 20000) hang("tx frame");
        repeat (3) @(posedge mclk);
        bt = u_peer.busy_ticks;
    endtask : send_frame

    task automatic rxb(input logic [7:0] d);
        u_peer.send_bits({~^d, d}, 9);
        repeat (2) @(posedge mclk);
    endtask : rxb

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rdc("rate reset", `NFBR_IDX_RATE, 8'h00);
        rdc("frame reset", `NFBR_IDX_FRAME, 8'h00);
        chk("pulse reset", 32'd35, pulse_width);
        wb(1'b1, `NFBR_IDX_RATE, 8'hFF);
        rdc("rate reserved", `NFBR_IDX_RATE, 8'h33);
        rdc("unmapped", 6'h10, 8'h00);
        for (int k = 0; k < 12; k++) begin
            wb(1'b1, `NFBR_IDX_RATE, {2'b00, 2'(t_rate[k]), 2'b00, 2'(t_rate[k])});
            wb(1'b1, `NFBR_IDX_FRAME, {3'b000, t_code[k], 1'b0});
            chk("link enabled", 32'(t_pw[k] != 0), link_enabled);
            if (t_pw[k] != 0) chk("pulse width", t_pw[k], pulse_width);
        end
        // Refused start while the code is unsupported for the rate
        wb(1'b1, `NFBR_IDX_RATE, 8'h11);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h0E);
        @(posedge mclk);
        tx_start <= 1'b1;
        @(posedge mclk);
        tx_start <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("tx refused", 32'd0, tx_busy);
        wb(1'b1, `NFBR_IDX_RATE, 8'h00);
        send_frame(8'hA5);
        chk("pauses parity", 32'd5, u_peer.n_pause);
        chk("pause ticks", 32'd1, u_peer.last_pw >= 41 && u_peer.last_pw <= 43);
        chk("bit time 106", 32'd1, bt >= 1152 && bt <= 1156);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h8E);
        send_frame(8'hA5);
        chk("pauses no parity", 32'd4, u_peer.n_pause);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h2E);
        send_frame(8'hA5);
        chk("pauses transport", 32'd11, u_peer.n_pause);
        wb(1'b1, `NFBR_IDX_RATE, 8'h30);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h06);
        send_frame(8'hA5);
        chk("bit time 848", 32'd1, bt >= 144 && bt <= 148);
        chk("pause 848", 32'd1, u_peer.last_pw >= 7 && u_peer.last_pw <= 9);
        wb(1'b1, `NFBR_IDX_RATE, 8'h00);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h00);
        u_peer.frame_start();
        rxb(8'hA5);
        chk("rx byte", 32'h0000_00A5, rx_last);
        u_peer.send_bits({1'b0, 8'hA5}, 9);
        repeat (2) @(posedge mclk);
        rdc("parity error", `NFBR_IDX_STAT, 8'h05);
        chk("parity pin", 32'd1, rx_parity_err);
        wb(1'b1, `NFBR_IDX_STAT, 8'h04);
        rdc("error cleared", `NFBR_IDX_STAT, 8'h01);
        chk("parity pin clear", 32'd0, rx_parity_err);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h40);
        chk("raw mode", 32'd1, rx_raw_mode);
        u_peer.frame_start();
        u_peer.send_bits({1'b0, 8'h3C}, 8);
        repeat (2) @(posedge mclk);
        chk("raw byte", 32'h0000_003C, rx_last);
        wb(1'b1, `NFBR_IDX_RATE, 8'h01);
        chk("raw at 212", 32'd0, rx_raw_mode);
        wb(1'b1, `NFBR_IDX_RATE, 8'h00);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h20);
        u_peer.frame_start();
        bt = n_rx;
        rxb(8'hF0);
        rxb(8'h33);
        chk("start dropped", 32'(bt + 1), n_rx);
        chk("rx after start", 32'h0000_0033, rx_last);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h01);
        chk("anticollision", 32'd1, antcoll_frame);
        wb(1'b1, `NFBR_IDX_FRAME, 8'h00);
        wb(1'b1, `NFBR_IDX_MODE, 8'hEA);
        chk("detect f", 32'd1, detect_type_f_rate);
        chk("detect a", 32'd1, detect_type_a_rate);
        chk("load detect", 32'd2, rf_load_sel);
        wb(1'b1, `NFBR_IDX_MODE, 8'hC9);
        chk("detect f off", 32'd0, detect_type_f_rate);
        chk("load detect a", 32'd1, rf_load_sel);
        wb(1'b1, `NFBR_IDX_MODE, 8'h8A);
        chk("load passive", 32'd2, rf_load_sel);
        wb(1'b1, `NFBR_IDX_MODE, 8'h0A);
        chk("load initiator", 32'd0, rf_load_sel);
        stop_test();
    end
endmodule : tb
